// File: verilog/ros_seq.sv
// Receiver operating-state sequencer with APB configuration registers.
//
// Contract
// - After power up wait the selected crystal settle time, 310 us by default.
// - Mode bit picks stored or host configuration; host-driven is the default.
// - Host writes configuration at start; it is kept only until power loss.
// - Stored configuration is used unchanged with no host action.
// - Sleep timer enable exists, off after reset.
// - Sleep time 3 ms and up, default 10 ms, in self-running or when enabled; the code accepts any value, including 0 to 2 ms.
// - Receive timer enable exists, off after reset.
// - Receive time in 10 us steps, default 1 ms, in self-running or when enabled.
// - Extended receive time, default 200 ms, only with wake-on-radio and receive timer.
// - Receive early exit enable exists, off after reset.
// - After early exit go to idle hold or synthesizer settle; idle by default.
// - Clock output pin toggles only when clock output is enabled, off by default.
// - Output clock is base clock divided by 1 to 32, default divide by 2.
// - Wake-on-radio enable exists, off after reset.
// - Wake condition is preamble, or preamble then sync; preamble by default.
// - Calibrate low-power oscillator during power up, then periodically.
`default_nettype none
module ros_seq #(
    parameter int unsigned RECAL_MS = ros_pkg::RECAL_PERIOD_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stored configuration from non-volatile memory
    input wire logic nvm_sleep_en,
    input wire logic nvm_rx_en,
    input wire logic nvm_early_en,
    input wire logic nvm_exit_synth,
    input wire logic nvm_clock_out_en,
    input wire logic nvm_wor_en,
    input wire logic nvm_wor_sync,
    input wire logic [2:0] nvm_settle_sel,
    input wire logic [4:0] nvm_clock_out_div,
    input wire logic [26:0] nvm_sleep_ms,
    input wire logic [28:0] nvm_rx_t10,
    input wire logic [28:0] nvm_rx_ext_t10,
    // Radio events
    input wire logic preamble_det,
    input wire logic sync_det,
    input wire logic rx_exit_req,
    input wire logic synth_locked,
    // State outputs
    output logic [2:0] op_state,
    output logic rx_on,
    output logic low_power_oscillator_cal,
    output logic sys_clock_out_pin
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] ctrl;
        logic [26:0] sleep_ms;
        logic [28:0] rx_t10;
        logic [28:0] rx_ext_t10;
        logic [4:0] us_pre;
        logic [3:0] t10_pre;
        logic [6:0] ms_pre;
        ros_pkg::ros_state_t st;
        logic [28:0] cnt;
        logic extended;
        logic pre_seen;
        logic [15:0] recal_cnt;
        logic recal;
        logic [2:0] cal_ms;
        logic cmd_rx;
        logic cmd_idle;
        logic rx_on;
        logic osc_cal;
    } ros_seq_state_t;

    ros_seq_state_t s_q, s_d;
    logic rst_sync1_q, rst_sync2_q;

    // Reset is released through two flops so that release is clean at the clock.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    // Effective configuration.
    logic self_run;
    logic e_sleep_en, e_rx_en, e_early_en, e_exit_synth, e_clock_out_en, e_wor_en, e_wor_sync;
    logic [2:0] e_settle;
    logic [4:0] e_div;
    logic [26:0] e_sleep_ms;
    logic [28:0] e_rx, e_rx_ext;
    logic sleep_act, rx_act, wake;
    logic us_tick, t10_tick, ms_tick;
    logic acc, wr, rd;

    assign self_run = s_q.ctrl[ros_pkg::CTRL_MODE];

    always_comb begin
        if (self_run) begin
            e_sleep_en = nvm_sleep_en;
            e_rx_en = nvm_rx_en;
            e_early_en = nvm_early_en;
            e_exit_synth = nvm_exit_synth;
            e_clock_out_en = nvm_clock_out_en;
            e_wor_en = nvm_wor_en;
            e_wor_sync = nvm_wor_sync;
            e_settle = nvm_settle_sel;
            e_div = nvm_clock_out_div;
            e_sleep_ms = nvm_sleep_ms;
            e_rx = nvm_rx_t10;
            e_rx_ext = nvm_rx_ext_t10;
        end else begin
            e_sleep_en = s_q.ctrl[ros_pkg::CTRL_SLEEP_EN];
            e_rx_en = s_q.ctrl[ros_pkg::CTRL_RX_EN];
            e_early_en = s_q.ctrl[ros_pkg::CTRL_EARLY_EN];
            e_exit_synth = s_q.ctrl[ros_pkg::CTRL_EXIT_SYNTH];
            e_clock_out_en = s_q.ctrl[ros_pkg::CTRL_CLOCK_OUT_EN];
            e_wor_en = s_q.ctrl[ros_pkg::CTRL_WOR_EN];
            e_wor_sync = s_q.ctrl[ros_pkg::CTRL_WOR_SYNC];
            e_settle = s_q.ctrl[ros_pkg::CTRL_SETTLE_LSB +: 3];
            e_div = s_q.ctrl[ros_pkg::CTRL_DIV_LSB +: 5];
            e_sleep_ms = s_q.sleep_ms;
            e_rx = s_q.rx_t10;
            e_rx_ext = s_q.rx_ext_t10;
        end
    end

    assign sleep_act = self_run | e_sleep_en;
    assign rx_act = self_run | e_rx_en;
    // A sync word only counts once a preamble has been seen in this window.
    assign wake = e_wor_sync ? ((s_q.pre_seen | preamble_det) & sync_det) : preamble_det;

    assign us_tick = (s_q.us_pre == ros_pkg::US_PRE_LAST);
    assign t10_tick = us_tick && (s_q.t10_pre == ros_pkg::T10_LAST);
    assign ms_tick = t10_tick && (s_q.ms_pre == ros_pkg::MS_LAST);

    assign acc = psel && penable && s_q.pready;
    assign wr = acc && pwrite;
    assign rd = psel && penable && !s_q.pready && !pwrite;

    always_comb begin
        s_d = s_q;
        s_d.cmd_rx = 1'b0;
        s_d.cmd_idle = 1'b0;

        // Free-running prescalers; the first tick of a window may come early by under one step.
        s_d.us_pre = us_tick ? 5'h00 : s_q.us_pre + 5'h01;
        if (us_tick) begin
            s_d.t10_pre = (s_q.t10_pre == ros_pkg::T10_LAST) ? 4'h0 : s_q.t10_pre + 4'h1;
        end
        if (t10_tick) begin
            s_d.ms_pre = (s_q.ms_pre == ros_pkg::MS_LAST) ? 7'h00 : s_q.ms_pre + 7'h01;
        end

        // APB: answer one cycle into the access phase; writes land on the completing edge.
        s_d.pready = psel && penable && !s_q.pready;
        if (s_d.pready) begin
            s_d.pslverr = !(paddr inside {ros_pkg::OFS_CTRL, ros_pkg::OFS_SLEEP,
                ros_pkg::OFS_RX, ros_pkg::OFS_RX_EXT, ros_pkg::OFS_CMD,
                ros_pkg::OFS_STATUS});
        end else begin
            s_d.pslverr = 1'b0;
        end
        s_d.prdata = 32'h0;
        if (rd) begin
            case (paddr)
                ros_pkg::OFS_CTRL: s_d.prdata = {16'h0, s_q.ctrl};
                ros_pkg::OFS_SLEEP: s_d.prdata = {5'h0, s_q.sleep_ms};
                ros_pkg::OFS_RX: s_d.prdata = {3'h0, s_q.rx_t10};
                ros_pkg::OFS_RX_EXT: s_d.prdata = {3'h0, s_q.rx_ext_t10};
                ros_pkg::OFS_STATUS: s_d.prdata = {26'h0, s_q.recal, s_q.extended,
                    1'b0, s_q.st};
                default: s_d.prdata = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                ros_pkg::OFS_CTRL: s_d.ctrl = pwdata[15:0];
                ros_pkg::OFS_SLEEP: s_d.sleep_ms = pwdata[26:0];
                ros_pkg::OFS_RX: s_d.rx_t10 = pwdata[28:0];
                ros_pkg::OFS_RX_EXT: s_d.rx_ext_t10 = pwdata[28:0];
                ros_pkg::OFS_CMD: begin
                    s_d.cmd_rx = pwdata[ros_pkg::CMD_GO_RX];
                    s_d.cmd_idle = pwdata[ros_pkg::CMD_GO_IDLE];
                end
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end

        // Periodic oscillator recalibration, run in the background after power up.
        if (s_q.st != ros_pkg::ST_SETTLE && s_q.st != ros_pkg::ST_CAL && ms_tick) begin
            if (s_q.recal) begin
                if (s_q.cal_ms == 3'(ros_pkg::OSC_CAL_MS - 1)) begin
                    s_d.recal = 1'b0;
                    s_d.cal_ms = 3'h0;
                end else begin
                    s_d.cal_ms = s_q.cal_ms + 3'h1;
                end
            end else if (s_q.recal_cnt >= 16'(RECAL_MS - 1)) begin
                s_d.recal = 1'b1;
                s_d.recal_cnt = 16'h0;
            end else begin
                s_d.recal_cnt = s_q.recal_cnt + 16'h1;
            end
        end

        case (s_q.st)
            ros_pkg::ST_SETTLE: begin
                if (us_tick) begin
                    s_d.cnt = s_q.cnt + 29'h1;
                end
                if (s_q.cnt >= {17'h0, ros_pkg::XTAL_SETTLE_US[e_settle]}) begin
                    s_d.st = ros_pkg::ST_CAL;
                    s_d.cnt = 29'h0;
                end
            end
            ros_pkg::ST_CAL: begin
                if (ms_tick) begin
                    s_d.cnt = s_q.cnt + 29'h1;
                end
                if (s_q.cnt >= ros_pkg::OSC_CAL_TICKS) begin
                    s_d.st = ros_pkg::ST_SYNTH;
                    s_d.cnt = 29'h0;
                end
            end
            ros_pkg::ST_IDLE: begin
                if (s_q.cmd_rx) begin
                    s_d.st = ros_pkg::ST_SYNTH;
                end
            end
            ros_pkg::ST_SYNTH: begin
                s_d.cnt = 29'h0;
                s_d.extended = 1'b0;
                s_d.pre_seen = 1'b0;
                if (synth_locked) begin
                    s_d.st = ros_pkg::ST_RX;
                end
            end
            ros_pkg::ST_RX: begin
                if (t10_tick) begin
                    s_d.cnt = s_q.cnt + 29'h1;
                end
                if (preamble_det) begin
                    s_d.pre_seen = 1'b1;
                end
                if (e_early_en && rx_exit_req) begin
                    s_d.st = e_exit_synth ? ros_pkg::ST_SYNTH : ros_pkg::ST_IDLE;
                    s_d.cnt = 29'h0;
                end else if (e_wor_en && rx_act && !s_q.extended && wake) begin
                    s_d.extended = 1'b1;
                    s_d.cnt = 29'h0;
                end else if (rx_act && s_q.cnt >= (s_q.extended ? e_rx_ext : e_rx)) begin
                    s_d.st = sleep_act ? ros_pkg::ST_SLEEP : ros_pkg::ST_IDLE;
                    s_d.cnt = 29'h0;
                end
            end
            ros_pkg::ST_SLEEP: begin
                if (ms_tick) begin
                    s_d.cnt = s_q.cnt + 29'h1;
                end
                if (s_q.cnt >= {2'h0, e_sleep_ms}) begin
                    s_d.st = ros_pkg::ST_SYNTH;
                    s_d.cnt = 29'h0;
                end
            end
            default: begin
                s_d.st = ros_pkg::ST_IDLE;
            end
        endcase

        // Host idle command overrides any operating state once power up is done.
        if (s_q.cmd_idle && s_q.st != ros_pkg::ST_SETTLE && s_q.st != ros_pkg::ST_CAL) begin
            s_d.st = ros_pkg::ST_IDLE;
            s_d.cnt = 29'h0;
        end
        s_d.rx_on = (s_d.st == ros_pkg::ST_RX);
        s_d.osc_cal = (s_d.st == ros_pkg::ST_CAL) | s_d.recal;
    end

    always_ff @(posedge clock or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            s_q <= '0;
            s_q.ctrl[ros_pkg::CTRL_SETTLE_LSB +: 3] <= ros_pkg::RST_SETTLE_SEL;
            s_q.ctrl[ros_pkg::CTRL_DIV_LSB +: 5] <= ros_pkg::RST_CLOCK_OUT_DIV;
            s_q.sleep_ms <= ros_pkg::RST_SLEEP_MS;
            s_q.rx_t10 <= ros_pkg::RST_RX_T10;
            s_q.rx_ext_t10 <= ros_pkg::RST_RX_EXT_T10;
            s_q.st <= ros_pkg::ST_SETTLE;
        end else begin
            s_q <= s_d;
        end
    end

    ros_clk_div u_clk_div (
        .clock(clock),
        .rst_n(rst_sync2_q),
        .enable(e_clock_out_en),
        .div_sel(e_div),
        .clk_out(sys_clock_out_pin)
    );

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign op_state = s_q.st;
    assign rx_on = s_q.rx_on;
    assign low_power_oscillator_cal = s_q.osc_cal;
endmodule // ros_seq
`default_nettype wire

// File: verilog/ros_pkg.sv
// Constants shared by the receiver operation sequencer.
`default_nettype none
package ros_pkg;
    // Clock and derived tick rates.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam logic [4:0] US_PRE_LAST = 5'(CYC_PER_US - 1);
    localparam logic [3:0] T10_LAST = 4'h9;
    localparam logic [6:0] MS_LAST = 7'h63;
    // Low-power oscillator calibration.
    localparam int unsigned OSC_CAL_MS = 4;
    localparam logic [28:0] OSC_CAL_TICKS = 29'(OSC_CAL_MS);
    localparam int unsigned RECAL_PERIOD_MS = 1000;

    // Crystal settle times in microseconds, indexed by the settle select field.
    localparam logic [11:0] XTAL_SETTLE_US [0:7] = '{
        12'h04e, 12'h09b, 12'h136, 12'h26c, 12'h4d8, 12'h9b0, 12'h9b0, 12'h9b0};

    // APB register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLEEP = 8'h04;
    localparam logic [7:0] OFS_RX = 8'h08;
    localparam logic [7:0] OFS_RX_EXT = 8'h0c;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Control and command register field positions.
    localparam int unsigned CTRL_MODE = 0;
    localparam int unsigned CTRL_SLEEP_EN = 1;
    localparam int unsigned CTRL_RX_EN = 2;
    localparam int unsigned CTRL_EARLY_EN = 3;
    localparam int unsigned CTRL_EXIT_SYNTH = 4;
    localparam int unsigned CTRL_CLOCK_OUT_EN = 5;
    localparam int unsigned CTRL_WOR_EN = 6;
    localparam int unsigned CTRL_WOR_SYNC = 7;
    localparam int unsigned CTRL_SETTLE_LSB = 8;
    localparam int unsigned CTRL_DIV_LSB = 11;
    localparam int unsigned CMD_GO_RX = 0;
    localparam int unsigned CMD_GO_IDLE = 1;

    // Values after reset.
    localparam logic [2:0] RST_SETTLE_SEL = 3'h2;
    localparam logic [26:0] RST_SLEEP_MS = 27'h000000a;
    localparam logic [28:0] RST_RX_T10 = 29'h00000064;
    localparam logic [28:0] RST_RX_EXT_T10 = 29'h00004e20;
    localparam logic [4:0] RST_CLOCK_OUT_DIV = 5'h01;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b000,
        ST_CAL = 3'b001,
        ST_IDLE = 3'b010,
        ST_SYNTH = 3'b011,
        ST_RX = 3'b100,
        ST_SLEEP = 3'b101
    } ros_state_t;
endpackage : ros_pkg
`default_nettype wire

// File: verilog/ros_clk_div.sv
// Divided system clock output for the clock output pin.
`default_nettype none
module ros_clk_div (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [4:0] div_sel,
    // Pin
    output logic clk_out
);
    typedef struct packed {
        logic [4:0] cnt;
        logic out;
    } ros_div_t;

    ros_div_t s_q, s_d;

    // Output toggles every div_sel+1 cycles, so it is the half-rate base clock over div_sel+1.
    always_comb begin
        s_d = s_q;
        if (!enable) begin
            s_d.cnt = 5'h00;
            s_d.out = 1'b0;
        end else if (s_q.cnt >= div_sel) begin
            s_d.cnt = 5'h00;
            s_d.out = ~s_q.out;
        end else begin
            s_d.cnt = s_q.cnt + 5'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_out = s_q.out;
endmodule // ros_clk_div
`default_nettype wire

// File: bench/ros_host_model.sv
// Bus-master model of the host controller that loads the configuration.
`default_nettype none
module ros_host_model (
    // Clock
    input wire logic clock,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // The answer time is never assumed; a hang is left to the bench watchdog.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released bus must not keep showing the last address and data.
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule // ros_host_model
`default_nettype wire

// File: bench/ros_seq_sva.sv
// Port assertions for the receiver operation sequencer.
`default_nettype none
module ros_seq_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer
    input wire logic synth_locked,
    input wire logic [2:0] op_state,
    input wire logic rx_on,
    input wire logic low_power_oscillator_cal,
    input wire logic sys_clock_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st_q;
    logic [19:0] cnt_q;
    // Cycles spent in the current state, so fixed power-up windows can be measured.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= 3'h0;
            cnt_q <= 20'h0;
        end else begin
            st_q <= op_state;
            cnt_q <= (op_state != st_q) ? 20'h0 : cnt_q + 20'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_ready_one_after: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready late or early");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_rx_decode: assert property (rx_on == (op_state == 3'h4))
        else $error("rx_on differs from receive state");
    a_settle_len: assert property (st_q == 3'h0 && op_state != 3'h0 |->
        op_state == 3'h1 && cnt_q inside {[20'h01e14:20'h01e78]})
        else $error("crystal settle window wrong");
    a_cal_len: assert property (st_q == 3'h1 && op_state != 3'h1 |->
        op_state == 3'h3 && cnt_q inside {[20'h124f8:20'h18704]})
        else $error("calibration window wrong");
    a_cal_flag: assert property (op_state == 3'h1 |-> low_power_oscillator_cal)
        else $error("calibration flag low in power-up state");
    a_lock_to_rx: assert property (op_state == 3'h3 && synth_locked |-> ##[1:2] op_state == 3'h4)
        else $error("no receive after lock");
    a_pin_quiet: assert property (op_state inside {3'h0, 3'h1} |-> !sys_clock_out_pin)
        else $error("clock pin active while disabled");
    c_unmapped: cover property (pslverr);
    c_sleep: cover property (op_state == 3'h5);
    c_exit_idle: cover property (st_q == 3'h4 && op_state == 3'h2);
    c_recal: cover property (op_state != 3'h1 && low_power_oscillator_cal);
endmodule // ros_seq_sva
bind ros_seq ros_seq_sva u_sva (.clock, .reset_n, .psel, .penable, .prdata, .pready, .pslverr,
    .synth_locked, .op_state, .rx_on, .low_power_oscillator_cal, .sys_clock_out_pin);
`default_nettype wire

// File: bench/ros_seq_tb_top.sv
// Self-checking bench for the receiver operation sequencer.
`default_nettype none
module ros_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic nvm_sleep_en = 1'b0, nvm_rx_en = 1'b0, nvm_early_en = 1'b1, nvm_exit_synth = 1'b0;
    logic nvm_clock_out_en = 1'b1, nvm_wor_en = 1'b0, nvm_wor_sync = 1'b0, err;
    logic [2:0] nvm_settle_sel = 3'h0;
    logic [4:0] nvm_clock_out_div = 5'h00;
    logic [26:0] nvm_sleep_ms = 27'h1;
    logic [28:0] nvm_rx_t10 = 29'h1fffffff, nvm_rx_ext_t10 = 29'h14;
    logic preamble_det = 1'b0, sync_det = 1'b0, rx_exit_req = 1'b0, synth_locked = 1'b0;
    logic lock_en = 1'b1, rx_on, low_power_oscillator_cal, sys_clock_out_pin;
    logic [2:0] op_state;
    int errors = 0, num_checks = 0, n, d;
    ros_host_model i_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    // A short recalibration period lets the periodic window occur within the run.
    ros_seq #(.RECAL_MS(2)) i_dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .nvm_sleep_en, .nvm_rx_en, .nvm_early_en,
        .nvm_exit_synth, .nvm_clock_out_en, .nvm_wor_en, .nvm_wor_sync, .nvm_settle_sel,
        .nvm_clock_out_div, .nvm_sleep_ms, .nvm_rx_t10, .nvm_rx_ext_t10, .preamble_det,
        .sync_det, .rx_exit_req, .synth_locked, .op_state, .rx_on, .low_power_oscillator_cal,
        .sys_clock_out_pin);
    initial forever #20 clock = ~clock;
    always @(posedge clock) synth_locked <= lock_en & 1'($urandom);
    function automatic int rises_exp(input int div);
        return 640 / (2 * (div + 1));
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_in(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic st_chk(input string what, input logic [2:0] exp);
        check_eq(what, {29'h0, exp}, {29'h0, op_state});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_host.xfer(1'b1, a, v, rd, err);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0, rd, err);
        check_eq(what, exp, rd);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge clock);
        {sync_det, preamble_det, rx_exit_req} <= v;
        @(posedge clock);
        {sync_det, preamble_det, rx_exit_req} <= 3'h0;
        repeat (3) @(posedge clock);
    endtask
    task automatic wait_st(input logic [2:0] st);
        n = 0;
        while (op_state !== st && n < 200000) begin
            @(posedge clock);
            n++;
        end
        st_chk("state reached", st);
    endtask
    task automatic measure(input logic [2:0] st);
        n = 0;
        while (op_state === st && n < 60000) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic rises(input int exp);
        logic p;
        int c;
        p = sys_clock_out_pin;
        c = 0;
        repeat (640) begin
            @(posedge clock);
            c += int'(sys_clock_out_pin === 1'b1 && p === 1'b0);
            p = sys_clock_out_pin;
        end
        check_in("clock pin rises", exp - 1, exp + 1, c);
    endtask
    initial begin
        repeat (400000) @(posedge clock);
        errors++;
        summarize();
    end
    initial begin
        void'($urandom(66079));
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        wait_st(3'h4);
        rdchk("ctrl", 8'h00, 32'h00000a00);
        rdchk("sleep", 8'h04, 32'h0000000a);
        rdchk("rx", 8'h08, 32'h00000064);
        rdchk("rx ext", 8'h0c, 32'h00004e20);
        rdchk("unmapped", 8'h20, 32'h0);
        check_eq("slverr", 32'h1, {31'h0, err});
        rises(0);
        pulse(3'h1);
        repeat (300) @(posedge clock);
        st_chk("no timers", 3'h4);
        rnd = $urandom;
        wr(8'h04, rnd);
        rdchk("sleep rw", 8'h04, {5'h0, rnd[26:0]});
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h4);
        wr(8'h0c, 32'h14);
        $display("test defaults done");
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
            wr(8'h00, 32'h20 | (32'(d) << 11));
            rises(rises_exp(d));
        end
        $display("test clock pin done");
        lock_en <= 1'b0;
        wr(8'h00, 32'h8);
        pulse(3'h1);
        st_chk("exit to idle", 3'h2);
        wr(8'h10, 32'h1);
        repeat (4) @(posedge clock);
        st_chk("go receive", 3'h3);
        lock_en <= 1'b1;
        wait_st(3'h4);
        wr(8'h00, 32'h18);
        lock_en <= 1'b0;
        pulse(3'h1);
        st_chk("exit to synth", 3'h3);
        lock_en <= 1'b1;
        $display("test early exit done");
        wr(8'h00, 32'h6);
        wait_st(3'h5);
        measure(3'h5);
        check_in("sleep window", 25000, 50010, n);
        wait_st(3'h4);
        measure(3'h4);
        check_in("rx window", 750, 1010, n);
        st_chk("back to sleep", 3'h5);
        $display("test duty cycle done");
        n = 0;
        while (low_power_oscillator_cal !== 1'b1 && n < 60000) begin
            @(posedge clock);
            n++;
        end
        check_eq("recal flag", 32'h1, {31'h0, low_power_oscillator_cal});
        $display("test recal done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, 32'h44 | (32'(k) << 7));
            wr(8'h10, 32'h2);
            wr(8'h10, 32'h1);
            wait_st(3'h4);
            repeat (100) @(posedge clock);
            pulse((k == 0) ? 3'h2 : 3'h6);
            measure(3'h4);
            check_in("ext window", 4740, 5010, n);
            st_chk("idle after ext", 3'h2);
        end
        $display("test wake done");
        wr(8'h00, 32'h1);
        wr(8'h10, 32'h1);
        wait_st(3'h4);
        rises(rises_exp(0));
        pulse(3'h1);
        st_chk("stored exit", 3'h2);
        $display("test stored config done");
        // A second reset models power loss: host-written values must return to defaults.
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        st_chk("reset state", 3'h0);
        rdchk("ctrl reset", 8'h00, 32'h00000a00);
        rdchk("sleep reset", 8'h04, 32'h0000000a);
        $display("test reset done");
        summarize();
    end
endmodule // ros_seq_tb_top
`default_nettype wire
